// [fmt_pkg.sv]
// Package for the frame transmit block: field sizes, encodings, states.
// Assumes a 20 MHz system clock and a 10 Mbit/s line.
package fmt_pkg;

  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BIT_NS = 100;
  // Clock cycles per half-cell: 100 ns bit at 50 ns period
  localparam int unsigned HALF_CYC = (BIT_NS * (CLK_HZ / 1000000)) / 2000;
  localparam logic [5:0] PRE_BITS = 6'h3e;
  localparam logic [1:0] SFD_BITS = 2'h2;
  localparam logic [3:0] ADDR_BYTES = 4'h6;
  localparam logic [10:0] MIN_DATA = 11'h02e;
  localparam logic [10:0] MAX_DATA = 11'h5dc;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // Word passed through the buffer
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } fmt_word_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_PRE = 8'h02,
    ST_SFD = 8'h04,
    ST_HDR = 8'h08,
    ST_DATA = 8'h10,
    ST_PAD = 8'h20,
    ST_CRC = 8'h40,
    ST_DONE = 8'h80
  } fmt_state_t;

endpackage : fmt_pkg

// [fmt_buf2.sv]
// Two-entry valid/ready buffer for frame bytes.
// Assumes single clock, asynchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module fmt_buf2 #(
  parameter int unsigned WIDTH = 9
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign push = in_valid_i && (cnt_r != 2'h2);
  assign pop = (cnt_r != 2'h0) && out_ready_i;
  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = mem_r[rp_r];

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push) mem_r[wp_r] <= in_data_i;
  end

endmodule : fmt_buf2
`default_nettype wire

// [fmt_tx.sv]
// Frame transmitter: preamble, delimiter, header, padded data, CRC, Manchester.
// Assumes the controller offers bytes with valid/ready and a last flag,
// header bytes (addresses, length) first, payload at most the maximum size.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Frame opens with 62 alternating preamble bits
// - Two consecutive ones follow as delimiter
// - Destination then source address, six bytes each
// - Two-byte length field follows source address
// - Data field padded up to 46 bytes
// - Four-byte CRC over addresses through data
// - NRZ bytes with clock become one stream
// - Cell sends complement first, true second
// - Line runs at 10 Mbit/s, 100 ns cells
module fmt_tx #(
  parameter int unsigned HDR_BYTES = 14
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic byte_valid_i,
  output logic byte_ready_o,
  input wire logic [7:0] byte_data_i,
  input wire logic byte_last_i,
  output logic line_o,
  output logic line_en_o,
  output logic busy_o,
  output logic done_o
);

  // ----------------------------------------
  // CRC step
  // ----------------------------------------
  function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic d);
    logic fb;
    fb = c[31] ^ d;
    crc_bit = {c[30:0], 1'b0} ^ (fb ? fmt_pkg::CRC_POLY : 32'h00000000);
  endfunction : crc_bit

  // ----------------------------------------
  // Input buffer
  // ----------------------------------------
  fmt_pkg::fmt_word_t in_w;
  fmt_pkg::fmt_word_t buf_w;
  logic buf_valid;
  logic buf_ready;
  logic buf_in_ready;

  assign in_w.data = byte_data_i;
  assign in_w.last = byte_last_i;

  fmt_buf2 #(
    .WIDTH(9)
  ) u_buf (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .in_valid_i(byte_valid_i),
    .in_ready_o(buf_in_ready),
    .in_data_i(in_w),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_w)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  fmt_pkg::fmt_state_t st_r;
  logic half_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic [10:0] cnt_r;
  logic [31:0] crc_r;
  logic bit_end;
  logic need_byte;
  logic in_crc_span;
  logic cur_bit;
  logic ended_r;

  // One bit cell is two 50 ns halves
  assign bit_end = half_r;
  assign cur_bit = sh_r[0];
  // Pop as each byte enters the shifter, delimiter end included
  assign need_byte = bit_end &&
                     (((bit_r == 4'h7) &&
                       ((st_r == fmt_pkg::ST_HDR) || (st_r == fmt_pkg::ST_DATA))) ||
                      ((st_r == fmt_pkg::ST_SFD) &&
                       (cnt_r[1:0] == fmt_pkg::SFD_BITS - 2'h1)));
  assign buf_ready = (st_r == fmt_pkg::ST_IDLE) ? 1'b0 : (need_byte && !ended_r);

  // Room as it stands after this edge, so the registered ready never over-admits
  logic buf_pop;
  logic ready_nxt;
  assign buf_pop = buf_valid && buf_ready;
  assign ready_nxt = !((!buf_in_ready && !buf_pop) ||
                       (buf_valid && buf_in_ready && byte_valid_i && !buf_pop));
  assign in_crc_span = (st_r == fmt_pkg::ST_HDR) || (st_r == fmt_pkg::ST_DATA) ||
                       (st_r == fmt_pkg::ST_PAD);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_r <= 1'b0;
    end else if (st_r == fmt_pkg::ST_IDLE || st_r == fmt_pkg::ST_DONE) begin
      half_r <= 1'b0;
    end else begin
      half_r <= ~half_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= fmt_pkg::ST_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      cnt_r <= 11'h000;
      ended_r <= 1'b0;
    end else begin
      case (st_r)
        fmt_pkg::ST_IDLE: begin
          ended_r <= 1'b0;
          if (start_i && buf_valid) begin
            st_r <= fmt_pkg::ST_PRE;
            sh_r <= 8'h01;
            cnt_r <= 11'h000;
          end
        end
        fmt_pkg::ST_PRE: begin
          if (bit_end) begin
            sh_r <= {7'h00, ~sh_r[0]};
            if (cnt_r[5:0] == fmt_pkg::PRE_BITS - 6'h01) begin
              st_r <= fmt_pkg::ST_SFD;
              sh_r <= 8'h01;
              cnt_r <= 11'h000;
            end else begin
              cnt_r <= cnt_r + 11'h001;
            end
          end
        end
        fmt_pkg::ST_SFD: begin
          if (bit_end) begin
            sh_r <= 8'h01;
            if (cnt_r[1:0] == fmt_pkg::SFD_BITS - 2'h1) begin
              st_r <= fmt_pkg::ST_HDR;
              sh_r <= buf_w.data;
              bit_r <= 4'h0;
              cnt_r <= 11'h000;
            end else begin
              cnt_r <= cnt_r + 11'h001;
            end
          end
        end
        fmt_pkg::ST_HDR, fmt_pkg::ST_DATA, fmt_pkg::ST_PAD: begin
          if (bit_end) begin
            if (bit_r != 4'h7) begin
              sh_r <= {1'b0, sh_r[7:1]};
              bit_r <= bit_r + 4'h1;
            end else begin
              bit_r <= 4'h0;
              if (st_r == fmt_pkg::ST_HDR) begin
                // Addresses then length, all from the controller
                ended_r <= buf_w.last;
                if (cnt_r == 11'(HDR_BYTES - 1)) begin
                  st_r <= fmt_pkg::ST_DATA;
                  cnt_r <= 11'h000;
                end else begin
                  cnt_r <= cnt_r + 11'h001;
                end
              end else begin
                if (st_r == fmt_pkg::ST_DATA) ended_r <= ended_r | buf_w.last;
                cnt_r <= cnt_r + 11'h001;
              end
              if (st_r == fmt_pkg::ST_HDR && cnt_r != 11'(HDR_BYTES - 1)) begin
                sh_r <= buf_w.data;
              end else if (ended_r || st_r == fmt_pkg::ST_PAD) begin
                if (st_r != fmt_pkg::ST_HDR && cnt_r + 11'h001 >= fmt_pkg::MIN_DATA) begin
                  st_r <= fmt_pkg::ST_CRC;
                  sh_r <= 8'h00;
                  cnt_r <= 11'h000;
                end else begin
                  st_r <= fmt_pkg::ST_PAD;
                  sh_r <= fmt_pkg::PAD_BYTE;
                end
              end else begin
                sh_r <= buf_w.data;
              end
            end
          end
        end
        fmt_pkg::ST_CRC: begin
          if (bit_end) begin
            if (cnt_r == 11'h01f) begin
              st_r <= fmt_pkg::ST_DONE;
            end
            cnt_r <= cnt_r + 11'h001;
          end
        end
        default: begin
          st_r <= fmt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // CRC over header and data, preset during the delimiter
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      crc_r <= fmt_pkg::CRC_INIT;
    end else if (st_r == fmt_pkg::ST_SFD) begin
      crc_r <= fmt_pkg::CRC_INIT;
    end else if (bit_end && in_crc_span) begin
      crc_r <= crc_bit(crc_r, cur_bit);
    end else if (bit_end && st_r == fmt_pkg::ST_CRC) begin
      crc_r <= {crc_r[30:0], 1'b1};
    end
  end

  // ----------------------------------------
  // Manchester line output
  // ----------------------------------------
  logic tx_bit;
  logic active;
  assign tx_bit = (st_r == fmt_pkg::ST_CRC) ? ~crc_r[31] : cur_bit;
  assign active = (st_r != fmt_pkg::ST_IDLE) && (st_r != fmt_pkg::ST_DONE);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_o <= 1'b0;
      line_en_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      byte_ready_o <= 1'b0;
    end else begin
      // First half complement, second half true
      line_o <= active ? (half_r ? tx_bit : ~tx_bit) : 1'b0;
      line_en_o <= active;
      busy_o <= active;
      done_o <= (st_r == fmt_pkg::ST_DONE);
      byte_ready_o <= ready_nxt;
    end
  end

endmodule : fmt_tx
`default_nettype wire

// [fmt_tx_properties.sv]
// Checker on the fmt_tx line output.
// Assumes it is bound to every fmt_tx.
`timescale 1ns/10ps
`default_nettype none
module fmt_tx_properties (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic line_o,
  input wire logic line_en_o,
  input wire logic busy_o,
  input wire logic done_o
);
  // ------
  // Cycle index in frame
  // ------
  logic [15:0] cnt_r;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_r <= 16'h0000;
    else cnt_r <= line_en_o ? cnt_r + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_busy_en_same: assert property (busy_o == line_en_o) else $error("busy");
  a_cell_first_low: assert property ($rose(line_en_o) |-> !line_o) else $error("c");
  a_mid_cell_edge: assert property (line_en_o && cnt_r[0] |-> line_o != $past(line_o))
    else $error("mid");
  a_preamble_alt: assert property (line_en_o && cnt_r < 16'h007c |-> line_o == ^cnt_r[1:0])
    else $error("pre");
  a_delim_ones: assert property (line_en_o && cnt_r[15:2] == 14'h001f |-> line_o == cnt_r[0])
    else $error("sfd");
  a_frame_min: assert property ($fell(line_en_o) |-> $past(cnt_r) >= 16'h047f)
    else $error("short");
  a_whole_cells: assert property ($fell(line_en_o) |-> $past(cnt_r[0])) else $error("w");
  a_done_one: assert property (done_o |=> !done_o) else $error("done");
  a_done_after: assert property ($fell(line_en_o) |-> ##[0:2] done_o) else $error("end");
  c_min_frame: cover property ($fell(line_en_o) && $past(cnt_r) == 16'h047f);
  c_long_frame: cover property ($fell(line_en_o) && $past(cnt_r) > 16'h047f);
  c_done: cover property (done_o);
endmodule : fmt_tx_properties
bind fmt_tx fmt_tx_properties chk_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .line_o(line_o),
  .line_en_o(line_en_o), .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

// [fmt_up_model.sv]
// Upstream controller model: header and payload bytes on valid/ready.
// Assumes ready_i is the transmitter's registered room flag.
`timescale 1ns/10ps
`default_nettype none
module fmt_up_model (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic [10:0] len_i,
  input wire logic ready_i,
  output logic valid_o = 1'b0,
  output logic [7:0] data_o = 8'h00,
  output logic last_o = 1'b0
);
  // ------
  // Byte source
  // ------
  logic tk = 1'b0;
  int idx = 0;
  int tot;
  assign tot = 14 + ((len_i > 11'h5dc) ? 11'h5dc : len_i);
  function automatic logic [7:0] byte_at(input int i);
    if (i == 12) return {5'h00, len_i[10:8]};
    if (i == 13) return len_i[7:0];
    return 8'(i * 29) ^ 8'ha5;
  endfunction : byte_at
  always @(negedge mclk_i) tk <= valid_o && ready_i;
  always @(posedge mclk_i) begin
    #1;
    if (!rstn_i || !go_i) idx = 0;
    else if (tk) idx++;
    if (go_i && idx < tot && ready_i && !(slow_i && tk)) begin
      valid_o = 1'b1;
      data_o = byte_at(idx);
      last_o = (idx == tot - 1);
    end else begin
      valid_o = 1'b0;
      data_o = ~data_o;
      last_o = ~last_o;
    end
  end
endmodule : fmt_up_model
`default_nettype wire

// [fmt_tx_tb.sv]
// Testbench for fmt_tx: model feeds frames, line is decoded and judged.
// Assumes fmt_up_model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin miscompares++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module fmt_tx_tb;
  logic mclk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0, go = 1'b0, slow = 1'b0;
  logic [10:0] len = 11'h001;
  logic vld, rdy, last, line, en, busy, done;
  logic [7:0] dat;
  logic hv[$], ex[$];
  int miscompares = 0, n_compared = 0, ndone, nbusy;
  fmt_tx dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .start_i(start_i), .byte_valid_i(vld),
    .byte_ready_o(rdy), .byte_data_i(dat), .byte_last_i(last), .line_o(line),
    .line_en_o(en), .busy_o(busy), .done_o(done));
  fmt_up_model up_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .go_i(go), .slow_i(slow),
    .len_i(len), .ready_i(rdy), .valid_o(vld), .data_o(dat), .last_o(last));
  // ------
  // Frame driver and decoder
  // ------
  task automatic chk_range(input string nm, input int lo, input int hi);
    for (int i = lo; i < hi && 2 * i + 1 < hv.size(); i++) begin
      `CHK(nm, ex[i], hv[2 * i + 1])
      if (ex[i] !== hv[2 * i + 1]) break;
    end
  endtask : chk_range
  task automatic run_frame(input logic [10:0] n, input logic hold);
    logic [31:0] c;
    logic [7:0] b;
    int k;
    len = n;
    hv.delete();
    ex.delete();
    c = fmt_pkg::CRC_INIT;
    ndone = 0;
    nbusy = 0;
    k = 0;
    for (int i = 0; i < 64; i++) ex.push_back(i < 62 ? ~i[0] : 1'b1);
    for (int i = 0; i < ((n < 46) ? 60 : 14 + n); i++) begin
      b = (i < 14 + n) ? up_u.byte_at(i) : 8'h00;
      for (int j = 0; j < 8; j++) begin
        ex.push_back(b[j]);
        c = {c[30:0], 1'b0} ^ ((c[31] ^ b[j]) ? fmt_pkg::CRC_POLY : 32'h00000000);
      end
    end
    for (int j = 31; j >= 0; j--) ex.push_back(~c[j]);
    @(posedge mclk_i) #1;
    go = 1'b1;
    start_i = 1'b1;
    while (busy !== 1'b1 && k < 100) begin
      @(posedge mclk_i) #1;
      k++;
    end
    if (!hold) start_i = 1'b0;
    do begin
      @(negedge mclk_i);
      if (en === 1'b1) hv.push_back(line);
      if (done === 1'b1) ndone++;
      k++;
    end while (en === 1'b1 && k < 30000);
    repeat (8) begin
      @(negedge mclk_i);
      if (done === 1'b1) ndone++;
      if (busy !== 1'b0) nbusy++;
    end
    @(posedge mclk_i) #1;
    start_i = 1'b0;
    go = 1'b0;
    `CHK("ready", 1'b1, rdy)
    `CHK("bits", ex.size(), hv.size() / 2)
    chk_range("preamble", 0, 62);
    chk_range("delimiter", 62, 64);
    chk_range("addresses", 64, 160);
    chk_range("length", 160, 176);
    chk_range("data", 176, ex.size() - 32);
    chk_range("crc", ex.size() - 32, ex.size());
    `CHK("done", 1, ndone)
  endtask : run_frame
  task automatic t_pad_short();
    slow = 1'b0;
    run_frame(11'h001, 1'b0);
  endtask : t_pad_short
  task automatic t_min_slow();
    slow = 1'b1;
    run_frame(11'h02e, 1'b0);
  endtask : t_min_slow
  task automatic t_over_hold();
    slow = 1'b0;
    run_frame(11'h02f, 1'b1);
    `CHK("restart", 0, nbusy)
  endtask : t_over_hold
  task automatic summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial forever #25 mclk_i = ~mclk_i;
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    t_pad_short();
    t_min_slow();
    t_over_hold();
    summarize();
  end
endmodule : fmt_tx_tb
`default_nettype wire
